// >>> hdl/wtd_pkg.sv
// Constants shared by the wait table and shortcut decoder.
// Assumes 16-bit instruction words fetched by the microcore sequencer.
package wtd_pkg;

  // ********************************************************
  // Table geometry
  // ********************************************************
  localparam int ROW_COUNT = 5;
  localparam int ROW_W = 3;
  localparam int COND_W = 6;
  localparam int DISP_W = 5;
  localparam int ROUTE_W = 4;
  localparam int CUR_SEL_W = 2;
  localparam logic [ROW_W-1:0] ROW_LAST = 3'h4;

  // ********************************************************
  // Instruction patterns and field positions
  // ********************************************************
  localparam logic [1:0] REL_OPCODE = 2'h3;
  localparam logic [5:0] ABS_OPCODE = 6'h04;
  localparam logic [1:0] OUT_OPCODE_HI = 2'h2;
  localparam logic [1:0] OUT_OPCODE_LO = 2'h3;
  localparam logic [13:0] CUR_OPCODE = 14'h0D5E;
  localparam int DISP_MSB = 13;
  localparam int DISP_LSB = 9;
  localparam int JREG_BIT = 9;
  localparam int ROW_MSB = 8;
  localparam int ROW_LSB = 6;
  localparam int COND_MSB = 5;
  localparam int COND_LSB = 0;
  localparam int R1_MSB = 13;
  localparam int R1_LSB = 10;
  localparam int R2_MSB = 9;
  localparam int R2_LSB = 6;
  localparam int R3_MSB = 5;
  localparam int R3_LSB = 2;
  localparam int CUR_MSB = 1;
  localparam int CUR_LSB = 0;

  // ********************************************************
  // Condition codes
  // ********************************************************
  localparam logic [COND_W-1:0] C_FLAG_HIGH = 6'h10;
  localparam logic [COND_W-1:0] C_TC = 6'h20;
  localparam logic [COND_W-1:0] C_START_LOW = 6'h24;
  localparam logic [COND_W-1:0] C_START_HIGH = 6'h25;
  localparam logic [COND_W-1:0] C_DS_LOW = 6'h26;
  localparam logic [COND_W-1:0] C_SRC_LOW = 6'h29;
  localparam logic [COND_W-1:0] C_DS_HIGH = 6'h2C;
  localparam logic [COND_W-1:0] C_ALU_DONE = 6'h2F;
  localparam logic [COND_W-1:0] C_BOOST_HIGH = 6'h30;
  localparam logic [COND_W-1:0] C_BOOST_LOW = 6'h31;
  localparam logic [COND_W-1:0] C_CUR_HIGH = 6'h32;
  localparam logic [COND_W-1:0] C_CUR_LOW = 6'h38;
  localparam logic [COND_W-1:0] C_OWN_HIGH = 6'h3E;

  // ********************************************************
  // Output route codes and reset defaults
  // ********************************************************
  localparam logic [ROUTE_W-1:0] ROUTE_UNDEF = 4'hC;
  // Index is channel_index * 2 + core_index
  localparam logic [CUR_SEL_W-1:0] CUR_DEFAULT [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  localparam logic [ROUTE_W-1:0] R1_DEFAULT [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
  localparam logic [ROUTE_W-1:0] R2_DEFAULT [4] = '{4'h5, 4'h6, 4'h7, 4'h8};
  localparam logic [ROUTE_W-1:0] R3_DEFAULT [4] = '{4'h9, 4'hA, 4'hB, 4'h4};

  // Wait sequencing states
  typedef enum logic [2:0] {
    WTD_IDLE = 3'b001,
    WTD_WATCH = 3'b010,
    WTD_JUMP = 3'b100
  } wtd_state_t;

endpackage

// >>> hdl/wtd_wait_table.sv
// Row store of the wait table: condition code and destination per row.
// Assumes one write port driven by the instruction decoder.
`timescale 1ns/1ns
module wtd_wait_table #(
  parameter int ADDR_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [wtd_pkg::ROW_W-1:0] wr_row_i,
  input wire logic [wtd_pkg::COND_W-1:0] wr_cond_i,
  input wire logic [ADDR_W-1:0] wr_dest_i,
  output logic [wtd_pkg::ROW_COUNT*wtd_pkg::COND_W-1:0] row_cond_o,
  output logic [wtd_pkg::ROW_COUNT*ADDR_W-1:0] row_dest_o
);
  import wtd_pkg::*;

  // ********************************************************
  // One register pair per row
  // ********************************************************
  for (genvar g = 0; g < ROW_COUNT; g++) begin : g_row
    logic [COND_W-1:0] cond_r;
    logic [ADDR_W-1:0] dest_r;
    // Row written only when its own code is addressed
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cond_r <= '0;
        dest_r <= '0;
      end else if (wr_en_i && wr_row_i == ROW_W'(g)) begin
        cond_r <= wr_cond_i;
        dest_r <= wr_dest_i;
      end
    end
    // Row registers onto the packed outputs, one writer per slice
    assign row_cond_o[g*COND_W +: COND_W] = cond_r;
    assign row_dest_o[g*ADDR_W +: ADDR_W] = dest_r;
  end

endmodule

// >>> hdl/wtd_decoder.sv
// Decode and execute of wait table entries and output/current shortcuts.
// Assumes the sequencer presents one instruction per valid cycle with its
// code address, and holds wait_active_i while a wait instruction runs.
`timescale 1ns/1ns

module wtd_decoder #(
  parameter int ADDR_W = 10,
  parameter int CORE_INDEX = 0,
  parameter int CHANNEL_INDEX = 0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [ADDR_W-1:0] instr_addr_i,
  input wire logic [ADDR_W-1:0] jump_register_set0_i,
  input wire logic [ADDR_W-1:0] jump_register_set1_i,
  input wire logic wait_active_i,
  input wire logic [wtd_pkg::ROW_COUNT-1:0] wait_row_en_i,
  input wire logic [15:0] flags_i,
  input wire logic [3:0] terminal_count_i,
  input wire logic start_i,
  input wire logic [2:0] route_drain_source_high_i,
  input wire logic [2:0] route_source_feedback_i,
  input wire logic alu_done_i,
  input wire logic boost_voltage_high_i,
  input wire logic [5:0] current_fb_i,
  output logic wait_jump_o,
  output logic [ADDR_W-1:0] wait_target_o,
  output logic [wtd_pkg::CUR_SEL_W-1:0] current_route_select_o,
  output logic [wtd_pkg::ROUTE_W-1:0] output_route_one_o,
  output logic [wtd_pkg::ROUTE_W-1:0] output_route_two_o,
  output logic [wtd_pkg::ROUTE_W-1:0] output_route_three_o
);
  import wtd_pkg::*;

  localparam int DEF_IDX = CHANNEL_INDEX * 2 + CORE_INDEX;

  // ********************************************************
  // Instruction decode
  // ********************************************************
  logic is_rel;
  logic is_abs;
  logic is_out;
  logic is_cur;
  logic tbl_wr;
  logic [ROW_W-1:0] row_code;
  logic [ADDR_W-1:0] rel_dest;
  logic [ADDR_W-1:0] abs_dest;
  logic [ADDR_W-1:0] wr_dest;
  logic [ROW_COUNT*COND_W-1:0] row_cond;
  logic [ROW_COUNT*ADDR_W-1:0] row_dest;

  // Opcode recognition
  assign is_rel = instr_valid_i && instr_i[15:14] == REL_OPCODE;
  assign is_abs = instr_valid_i && instr_i[15:10] == ABS_OPCODE;
  assign is_out = instr_valid_i && instr_i[15:14] == OUT_OPCODE_HI
                  && instr_i[1:0] == OUT_OPCODE_LO;
  assign is_cur = instr_valid_i && instr_i[15:2] == CUR_OPCODE;
  assign row_code = instr_i[ROW_MSB:ROW_LSB];
  // Rows past the last one are dropped
  assign tbl_wr = (is_rel || is_abs) && row_code <= ROW_LAST;
  // Sign-extended displacement added to the instruction address
  assign rel_dest = instr_addr_i + ADDR_W'(signed'(instr_i[DISP_MSB:DISP_LSB]));
  // Jump register chosen by the select bit
  assign abs_dest = instr_i[JREG_BIT] ? jump_register_set1_i
                                      : jump_register_set0_i;
  assign wr_dest = is_rel ? rel_dest : abs_dest;

  // Row store
  wtd_wait_table #(
    .ADDR_W(ADDR_W)
  ) u_table (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(tbl_wr),
    .wr_row_i(row_code),
    .wr_cond_i(instr_i[COND_MSB:COND_LSB]),
    .wr_dest_i(wr_dest),
    .row_cond_o(row_cond),
    .row_dest_o(row_dest)
  );

  // ********************************************************
  // Shortcut state
  // ********************************************************
  // Current measurement block selection
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_route_select_o <= CUR_DEFAULT[DEF_IDX];
    end else if (is_cur) begin
      current_route_select_o <= instr_i[CUR_MSB:CUR_LSB];
    end
  end

  // Output routes; codes above undefined keep the old route
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_route_one_o <= R1_DEFAULT[DEF_IDX];
      output_route_two_o <= R2_DEFAULT[DEF_IDX];
      output_route_three_o <= R3_DEFAULT[DEF_IDX];
    end else if (is_out) begin
      if (instr_i[R1_MSB:R1_LSB] <= ROUTE_UNDEF) begin
        output_route_one_o <= instr_i[R1_MSB:R1_LSB];
      end
      if (instr_i[R2_MSB:R2_LSB] <= ROUTE_UNDEF) begin
        output_route_two_o <= instr_i[R2_MSB:R2_LSB];
      end
      if (instr_i[R3_MSB:R3_LSB] <= ROUTE_UNDEF) begin
        output_route_three_o <= instr_i[R3_MSB:R3_LSB];
      end
    end
  end

  // ********************************************************
  // Condition evaluation
  // ********************************************************
  logic own_cur;
  logic [ROW_COUNT-1:0] row_hit;
  logic [ADDR_W-1:0] hit_dest;

  // Own feedback follows the current route selection
  assign own_cur = current_fb_i[current_route_select_o];

  // One condition code against the live inputs
  // Ranges tested in code order; the last branch is own feedback low
  function automatic logic cond_true(input logic [COND_W-1:0] c);
    logic [COND_W-1:0] d;
    d = '0;
    if (c < C_FLAG_HIGH) begin
      cond_true = !flags_i[c[3:0]];
    end else if (c < C_TC) begin
      cond_true = flags_i[c[3:0]];
    end else if (c < C_START_LOW) begin
      cond_true = terminal_count_i[c[1:0]];
    end else if (c == C_START_LOW) begin
      cond_true = !start_i;
    end else if (c == C_START_HIGH) begin
      cond_true = start_i;
    end else if (c < C_SRC_LOW) begin
      d = c - C_DS_LOW;
      cond_true = !route_drain_source_high_i[d[1:0]];
    end else if (c < C_DS_HIGH) begin
      d = c - C_SRC_LOW;
      cond_true = !route_source_feedback_i[d[1:0]];
    end else if (c < C_ALU_DONE) begin
      d = c - C_DS_HIGH;
      cond_true = route_drain_source_high_i[d[1:0]];
    end else if (c == C_ALU_DONE) begin
      cond_true = alu_done_i;
    end else if (c == C_BOOST_HIGH) begin
      cond_true = boost_voltage_high_i;
    end else if (c == C_BOOST_LOW) begin
      cond_true = !boost_voltage_high_i;
    end else if (c < C_CUR_LOW) begin
      d = c - C_CUR_HIGH;
      cond_true = current_fb_i[d[2:0]];
    end else if (c < C_OWN_HIGH) begin
      d = c - C_CUR_LOW;
      cond_true = !current_fb_i[d[2:0]];
    end else if (c == C_OWN_HIGH) begin
      cond_true = own_cur;
    end else begin
      cond_true = !own_cur;
    end
  endfunction

  // All enabled rows watched side by side
  // A process, not a plain assign: inputs read inside the function wake it
  for (genvar g = 0; g < ROW_COUNT; g++) begin : g_hit
    logic hit;
    always_comb begin
      hit = wait_row_en_i[g] && cond_true(row_cond[g*COND_W +: COND_W]);
    end
    assign row_hit[g] = hit;
  end

  // Lowest-numbered true row supplies the destination
  always_comb begin
    hit_dest = '0;
    for (int i = ROW_COUNT - 1; i >= 0; i--) begin
      if (row_hit[i]) begin
        hit_dest = row_dest[i*ADDR_W +: ADDR_W];
      end
    end
  end

  // ********************************************************
  // Wait sequencing
  // ********************************************************
  wtd_state_t state_r;
  wtd_state_t state_nxt;

  // Next state of the wait watcher
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WTD_IDLE: begin
        if (wait_active_i) begin
          state_nxt = WTD_WATCH;
        end
      end
      WTD_WATCH: begin
        if (!wait_active_i) begin
          state_nxt = WTD_IDLE;
        end else if (|row_hit) begin
          state_nxt = WTD_JUMP;
        end
      end
      WTD_JUMP: begin
        // Back to idle, so one hit gives a single pulse
        state_nxt = WTD_IDLE;
      end
      default: begin
        state_nxt = WTD_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= WTD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Jump pulse and target captured on a hit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_jump_o <= 1'b0;
      wait_target_o <= '0;
    end else begin
      wait_jump_o <= state_nxt == WTD_JUMP;
      if (state_nxt == WTD_JUMP) begin
        wait_target_o <= hit_dest;
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [ROW_W-1:0] row_q;
  logic [ROW_COUNT*ADDR_W-1:0] dest_q;
  logic [ROW_COUNT*COND_W-1:0] cond_q;
  // Helper copies for row-indexed checks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_q <= '0;
    end else begin
      row_q <= row_code;
    end
  end
  assign dest_q = row_dest >> (row_q * ADDR_W);
  assign cond_q = row_cond >> (row_q * COND_W);

  chk_rel_dest_store: assert property (
    is_rel && row_code <= ROW_LAST |=> dest_q[ADDR_W-1:0] == $past(rel_dest))
    else $error("relative destination not stored");
  chk_abs_dest_store: assert property (
    is_abs && row_code <= ROW_LAST |=> dest_q[ADDR_W-1:0] == $past(abs_dest))
    else $error("absolute destination not stored");
  chk_bad_row_hold: assert property (
    (is_rel || is_abs) && row_code > ROW_LAST |=> $stable(row_cond) && $stable(row_dest))
    else $error("unused row code changed the table");
  chk_cur_route_load: assert property (
    is_cur |=> current_route_select_o == $past(instr_i[CUR_MSB:CUR_LSB]))
    else $error("current route not loaded");
  chk_out_route_load: assert property (
    is_out && instr_i[R2_MSB:R2_LSB] <= ROUTE_UNDEF
    |=> output_route_two_o == $past(instr_i[R2_MSB:R2_LSB]))
    else $error("output route two not loaded");
  chk_out_route_keep: assert property (
    is_out && instr_i[R1_MSB:R1_LSB] > ROUTE_UNDEF |=> $stable(output_route_one_o))
    else $error("invalid route code changed route one");
  chk_wait_jump_hit: assert property (
    state_r == WTD_WATCH && wait_active_i && |row_hit
    |=> wait_jump_o && wait_target_o == $past(hit_dest) ##1 !wait_jump_o)
    else $error("hit did not give one jump to the row destination");
  chk_no_jump_idle: assert property (
    !wait_active_i ##1 !wait_active_i |=> !wait_jump_o)
    else $error("jump without a running wait");
  chk_routes_quiet: assert property (
    !is_out && !is_cur |=> $stable(output_route_three_o) && $stable(current_route_select_o))
    else $error("routes changed without an instruction");

  // Further table, route and wait checks
  chk_cond_store: assert property (
    tbl_wr |=> cond_q[COND_W-1:0] == $past(instr_i[COND_MSB:COND_LSB]))
    else $error("row condition not stored");
  chk_table_quiet: assert property (
    !tbl_wr |=> $stable(row_cond) && $stable(row_dest))
    else $error("table changed without a valid entry");
  chk_out_route_one: assert property (
    is_out && instr_i[R1_MSB:R1_LSB] <= ROUTE_UNDEF
    |=> output_route_one_o == $past(instr_i[R1_MSB:R1_LSB]))
    else $error("output route one not loaded");
  chk_out_route_three: assert property (
    is_out && instr_i[R3_MSB:R3_LSB] <= ROUTE_UNDEF
    |=> output_route_three_o == $past(instr_i[R3_MSB:R3_LSB]))
    else $error("output route three not loaded");
  chk_jump_from_watch: assert property (
    wait_jump_o |-> $past(wait_active_i) && $past(state_r) == WTD_WATCH)
    else $error("jump not preceded by a watched wait");
  chk_first_row_wins: assert property (
    state_r == WTD_WATCH && wait_active_i && row_hit[0]
    |=> wait_target_o == $past(row_dest[ADDR_W-1:0]))
    else $error("row one hit did not give its destination");
  chk_target_hold: assert property (
    state_nxt != WTD_JUMP |=> $stable(wait_target_o))
    else $error("jump target changed without a hit");

  cov_rel_entry: cover property (tbl_wr && is_rel && instr_i[DISP_MSB]);
  cov_abs_entry: cover property (tbl_wr && is_abs && instr_i[JREG_BIT]);
  cov_jump: cover property (wait_jump_o);
  cov_out_undef: cover property (is_out && instr_i[R3_MSB:R3_LSB] == ROUTE_UNDEF);
  cov_cur_load: cover property (is_cur && instr_i[CUR_MSB:CUR_LSB] == 2'h3);

endmodule

// >>> verification/wtd_seq_model.sv
// Sequencer model that feeds instructions and runs wait instructions.
// Assumes the decoder takes a word at the edge where valid is high.
`timescale 1ns/1ns
module wtd_seq_model #(
  parameter int ADDR_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic wait_jump_i,
  input wire logic [ADDR_W-1:0] wait_target_i,
  output logic instr_valid_o,
  output logic [15:0] instr_o,
  output logic [ADDR_W-1:0] instr_addr_o,
  output logic wait_active_o,
  output logic [4:0] wait_row_en_o
);
  // ********************************************************
  // Idle levels at time zero
  // ********************************************************
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 16'hFFFF;
    instr_addr_o = '1;
    wait_active_o = 1'b0;
    wait_row_en_o = 5'h00;
  end

  // One instruction, taken at the second edge; word inverted when idle
  task automatic exec(input logic [15:0] w, input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_i);
    instr_valid_o <= 1'b1;
    instr_o <= w;
    instr_addr_o <= a;
    @(posedge ref_clk_i);
    instr_valid_o <= 1'b0;
    instr_o <= ~w;
    instr_addr_o <= ~a;
  endtask

  // Wait with given row enables, bounded watch, drop on jump
  task automatic run_wait(input logic [4:0] en, output logic hit,
                          output logic [ADDR_W-1:0] tgt);
    hit = 1'b0;
    tgt = '0;
    @(posedge ref_clk_i);
    wait_active_o <= 1'b1;
    wait_row_en_o <= en;
    repeat (6) begin
      @(posedge ref_clk_i);
      #1;
      if (wait_jump_i === 1'b1) begin
        hit = 1'b1;
        tgt = wait_target_i;
        break;
      end
    end
    @(posedge ref_clk_i);
    wait_active_o <= 1'b0;
    wait_row_en_o <= ~en;
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the wait table and shortcut decoder.
// Assumes the sequencer model drives the instruction and wait ports.
`timescale 1ns/1ns
module tb;
  import wtd_pkg::*;
  localparam int AW = 10;
  logic ref_clk_i, rst_n_i, hit_v, p;
  logic [34:0] src_v;
  logic [AW-1:0] jreg0_v, jreg1_v, tgt_v, addr_v, exp_v;
  logic instr_valid, wait_active, wait_jump;
  logic [15:0] instr;
  logic [AW-1:0] instr_addr, wait_target;
  logic [4:0] row_en;
  logic [1:0] cur_sel, cur_sel_b, cur_exp;
  logic [3:0] r1, r2, r3, r1b, r2b, r3b;
  logic [4:0] disp_t [5] = '{5'h10, 5'h0F, 5'h01, 5'h1F, 5'h00};
  int n_fail, comparisons, b;

  // ********************************************************
  // Clock, design and partner
  // ********************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  wtd_seq_model #(.ADDR_W(AW)) seq (.ref_clk_i(ref_clk_i), .wait_jump_i(wait_jump),
    .wait_target_i(wait_target), .instr_valid_o(instr_valid), .instr_o(instr),
    .instr_addr_o(instr_addr), .wait_active_o(wait_active), .wait_row_en_o(row_en));

  wtd_decoder #(.ADDR_W(AW), .CORE_INDEX(1), .CHANNEL_INDEX(0)) uut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .instr_valid_i(instr_valid), .instr_i(instr),
    .instr_addr_i(instr_addr), .jump_register_set0_i(jreg0_v),
    .jump_register_set1_i(jreg1_v), .wait_active_i(wait_active), .wait_row_en_i(row_en),
    .flags_i(src_v[15:0]), .terminal_count_i(src_v[19:16]), .start_i(src_v[20]),
    .route_drain_source_high_i(src_v[23:21]), .route_source_feedback_i(src_v[26:24]),
    .alu_done_i(src_v[27]), .boost_voltage_high_i(src_v[28]),
    .current_fb_i(src_v[34:29]), .wait_jump_o(wait_jump), .wait_target_o(wait_target),
    .current_route_select_o(cur_sel), .output_route_one_o(r1),
    .output_route_two_o(r2), .output_route_three_o(r3));

  // Second instance only for the other reset defaults
  wtd_decoder #(.ADDR_W(AW), .CORE_INDEX(1), .CHANNEL_INDEX(1)) uut_b (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .instr_valid_i(1'b0), .instr_i(instr), .instr_addr_i(instr_addr),
    .jump_register_set0_i(jreg0_v), .jump_register_set1_i(jreg1_v),
    .wait_active_i(wait_active), .wait_row_en_i(row_en), .flags_i(src_v[15:0]),
    .terminal_count_i(src_v[19:16]), .start_i(src_v[20]),
    .route_drain_source_high_i(src_v[23:21]), .route_source_feedback_i(src_v[26:24]),
    .alu_done_i(src_v[27]), .boost_voltage_high_i(src_v[28]),
    .current_fb_i(src_v[34:29]), .wait_jump_o(), .wait_target_o(),
    .current_route_select_o(cur_sel_b), .output_route_one_o(r1b),
    .output_route_two_o(r2b), .output_route_three_o(r3b));

  // ********************************************************
  // Helpers
  // ********************************************************
  // Level at which a condition code is true (1 = high)
  function automatic logic pol(input logic [5:0] c);
    if (c < 6'h10 || c == 6'h24 || (c >= 6'h26 && c < 6'h2C) || c == 6'h31) return 1'b0;
    if ((c >= 6'h38 && c < 6'h3E) || c == 6'h3F) return 1'b0;
    return 1'b1;
  endfunction

  // Bit of the source vector tested by a condition code
  function automatic int sidx(input logic [5:0] c, input logic [1:0] own);
    if (c < 6'h10) return int'(c);
    if (c < 6'h20) return int'(c) - 16;
    if (c < 6'h24) return int'(c) - 16;
    if (c < 6'h26) return 20;
    if (c < 6'h29) return int'(c) - 17;
    if (c < 6'h2C) return int'(c) - 17;
    if (c < 6'h2F) return int'(c) - 23;
    if (c == 6'h2F) return 27;
    if (c < 6'h32) return 28;
    if (c < 6'h38) return int'(c) - 21;
    if (c < 6'h3E) return int'(c) - 27;
    return 29 + int'(own);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic set_src(input logic [34:0] v);
    @(posedge ref_clk_i);
    src_v <= v;
  endtask

  task automatic chk_routes(input logic [3:0] a, input logic [3:0] b2, input logic [3:0] c3);
    #1;
    chk(16'(r1), 16'(a), "route one");
    chk(16'(r2), 16'(b2), "route two");
    chk(16'(r3), 16'(c3), "route three");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ********************************************************
  // Watchdog
  // ********************************************************
  initial begin
    #400000;
    n_fail++;
    $display("MISMATCH t=%0t run did not finish", $time);
    close_out();
  end

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    rst_n_i = 1'b0;
    src_v = '0;
    jreg0_v = 10'h2A5;
    jreg1_v = 10'h15A;
    n_fail = 0;
    comparisons = 0;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    // Reset defaults for core index 1 at channel index 0 (uut) and channel index 1 (uut_b)
    chk(16'(cur_sel), 16'h0001, "cur default");
    chk_routes(4'h1, 4'h6, 4'hA);
    chk(16'(cur_sel_b), 16'h0003, "cur default b");
    chk({4'h0, r1b, r2b, r3b}, 16'h0384, "route default b");
    $display("test reset defaults done");
    // Every current select code
    for (int s = 0; s < 4; s++) begin
      seq.exec({14'h0D5E, 2'(s)}, 10'h010);
      #1;
      chk(16'(cur_sel), 16'(s), "cur select");
    end
    cur_exp = 2'h3;
    $display("test current route done");
    // Every route code, then unused codes keep only their own field
    for (int k = 0; k < 13; k++) begin
      seq.exec({2'h2, 4'(k), 4'(12 - k), 4'(k), 2'h3}, 10'h020);
      chk_routes(4'(k), 4'(12 - k), 4'(k));
    end
    seq.exec({2'h2, 4'hD, 4'h3, 4'hF, 2'h3}, 10'h021);
    chk_routes(4'hC, 4'h3, 4'hC);
    $display("test output routes done");
    // Every condition code: true, all false, wrong bit
    for (int c = 0; c < 64; c++) begin
      p = pol(6'(c));
      b = sidx(6'(c), cur_exp);
      exp_v = AW'(10'h100 + c);
      seq.exec({2'h3, 5'h00, 3'h0, 6'(c)}, exp_v);
      set_src({35{~p}} ^ (35'h1 << b));
      seq.run_wait(5'h01, hit_v, tgt_v);
      chk(16'(hit_v), 16'h0001, "cond hit");
      chk(16'(tgt_v), 16'(exp_v), "cond dest");
      set_src({35{~p}});
      seq.run_wait(5'h01, hit_v, tgt_v);
      chk(16'(hit_v), 16'h0000, "cond false");
      set_src({35{p}} ^ (35'h1 << b));
      seq.run_wait(5'h01, hit_v, tgt_v);
      chk(16'(hit_v), 16'h0000, "cond wrong bit");
    end
    $display("test condition codes done");
    // Relative rows at displacement limits, wrap, unused row code
    for (int r = 0; r < 5; r++) begin
      addr_v = (r == 0) ? 10'h003 : 10'h200;
      seq.exec({2'h3, disp_t[r], 3'(r), 6'h10}, addr_v);
    end
    seq.exec({2'h3, 5'h05, 3'h5, 6'h10}, 10'h300);
    set_src(35'h1);
    for (int r = 0; r < 5; r++) begin
      addr_v = (r == 0) ? 10'h003 : 10'h200;
      exp_v = addr_v + {{5{disp_t[r][4]}}, disp_t[r]};
      seq.run_wait(5'(1 << r), hit_v, tgt_v);
      chk(16'(tgt_v), 16'(exp_v), "relative dest");
    end
    seq.run_wait(5'h1F, hit_v, tgt_v);
    chk(16'(tgt_v), 16'h03F3, "all rows enabled");
    $display("test relative rows done");
    // Absolute rows from both jump registers
    seq.exec({6'h04, 1'b0, 3'h2, 6'h10}, 10'h040);
    seq.exec({6'h04, 1'b1, 3'h4, 6'h10}, 10'h041);
    seq.run_wait(5'h04, hit_v, tgt_v);
    chk(16'(tgt_v), 16'h02A5, "absolute set0");
    seq.run_wait(5'h10, hit_v, tgt_v);
    chk(16'(tgt_v), 16'h015A, "absolute set1");
    $display("test absolute rows done");
    close_out();
  end
endmodule
